// ==== design/clk_rst_seq.sv ====
// Our own choices: the AXI4-Lite interface to the registers and the register addresses.
module clk_rst_seq
  import clk_rst_pkg::*;
#(
  parameter int FAST_DIV_P    = clk_rst_pkg::FAST_DIV,
  parameter int SLOW_DIV_P    = clk_rst_pkg::SLOW_DIV,
  parameter int PUP_OSC_DIV_P = clk_rst_pkg::PUP_OSC_DIV,
  parameter int PUP_TICKS_P   = clk_rst_pkg::PUP_TICKS,
  parameter int FILT_CYC_P    = clk_rst_pkg::FILT_CYC,
  parameter int START_CYC_P   = clk_rst_pkg::STARTUP_CYC
) (
  input  wire logic        MCLK,
  input  wire logic        RST_B,
  input  wire logic        AWVALID,
  output logic             AWREADY,
  input  wire logic [7:0]  AWADDR,
  input  wire logic        WVALID,
  output logic             WREADY,
  input  wire logic [31:0] WDATA,
  input  wire logic [3:0]  WSTRB,
  output logic             BVALID,
  input  wire logic        BREADY,
  output logic [1:0]       BRESP,
  input  wire logic        ARVALID,
  output logic             ARREADY,
  input  wire logic [7:0]  ARADDR,
  output logic             RVALID,
  input  wire logic        RREADY,
  output logic [31:0]      RDATA,
  output logic [1:0]       RRESP,
  input  wire logic        POWER_GOOD,
  input  wire logic        BROWN_OUT,
  input  wire logic        MASTER_CLEAR_B,
  input  wire logic        WATCHDOG_EXPIRED,
  input  wire logic        CORE_SLEEP,
  input  wire logic        OSC_IN_PIN,
  input  wire logic        GPIO_OUT,
  input  wire logic        GPIO_OE,
  output logic             SYS_CLK_EN,
  output logic             CORE_RST_B,
  output logic             OSC_OUT_PIN_O,
  output logic             OSC_OUT_PIN_OE
);
  import clk_rst_pkg::*;

  localparam int FW = $clog2(FAST_DIV_P + 1);
  localparam int SW = $clog2(SLOW_DIV_P + 1);
  localparam int PW = $clog2(PUP_OSC_DIV_P + 1);
  localparam int TW = $clog2(PUP_TICKS_P + 1);
  localparam int LW = $clog2(FILT_CYC_P + 1);
  localparam int OW = $clog2(START_CYC_P + 1);

  typedef struct packed {
    logic          awready;
    logic          wready;
    logic          bvalid;
    logic [1:0]    bresp;
    logic          arready;
    logic          rvalid;
    logic [1:0]    rresp;
    logic [31:0]   rdata;
    logic [2:0]    fosc;
    logic          pup_dis;
    logic          bo_en;
    logic          spd_sel;
    logic          pon_n;
    logic          bo_n;
    logic          tmo;
    logic          pdn;
    cause_t        cause;
    logic [7:0]    keep;
    logic [FW-1:0] fast_cnt;
    logic [SW-1:0] slow_cnt;
    logic [PW-1:0] pup_osc;
    logic [TW-1:0] pup_cnt;
    logic [OW-1:0] start_cnt;
    logic [LW-1:0] filt_cnt;
    seq_t          seq;
    logic          in_reset;
    logic          active_fast;
    spd_t          sw;
    logic [2:0]    sw_cnt;
    logic          clk_en;
    logic [1:0]    phase;
    logic          osc_in_d;
    logic          pin_o;
    logic          pin_oe;
  } state_t;

  state_t st_ff;
  state_t nxt_st;

  logic fast_tick, slow_tick, pup_tick, act_tick, osc_tick, pin_edge;
  logic internal, crystal, divided_clock_out_mode, gpio_mode, pin_rst, bo_evt;
  logic want_switch, run, wr_go, rd_go;

  // free-running dividers: the ticks exist even while the core is halted
  assign fast_tick = (st_ff.fast_cnt == FW'(FAST_DIV_P - 1));
  assign slow_tick = (st_ff.slow_cnt == SW'(SLOW_DIV_P - 1));
  assign pup_tick  = (st_ff.pup_osc == PW'(PUP_OSC_DIV_P - 1));
  assign act_tick  = st_ff.active_fast ? fast_tick : slow_tick;
  assign pin_edge  = OSC_IN_PIN & ~st_ff.osc_in_d;
  assign internal  = (st_ff.fosc == MODE_INT_GPIO) || (st_ff.fosc == MODE_INT_DIVIDED_CLOCK_OUT);
  assign crystal   = (st_ff.fosc < MODE_EXT_CLOCK);
  assign divided_clock_out_mode = (st_ff.fosc == MODE_INT_DIVIDED_CLOCK_OUT) || (st_ff.fosc == MODE_RESCAP_DIVIDED_CLOCK_OUT);
  assign gpio_mode = (st_ff.fosc == MODE_INT_GPIO) || (st_ff.fosc == MODE_RESCAP_GPIO)
                  || (st_ff.fosc == MODE_EXT_CLOCK);
  assign osc_tick  = internal ? act_tick : pin_edge;  // see R19 see R20
  assign pin_rst   = (st_ff.filt_cnt == LW'(FILT_CYC_P));
  assign bo_evt    = st_ff.bo_en & BROWN_OUT;
  assign want_switch = internal && (st_ff.spd_sel != st_ff.active_fast);  // see R02 see R05
  assign run       = (st_ff.seq == SQ_RUN) && (st_ff.sw == SW_IDLE) && !want_switch;
  assign wr_go     = st_ff.awready & AWVALID & st_ff.wready & WVALID;
  assign rd_go     = st_ff.arready & ARVALID;

  function automatic seq_t first_timer(input logic dis, input logic xtal);
    return seq_t'(!dis ? SQ_PUP : (xtal ? SQ_START : SQ_HOLD));  // see R17
  endfunction

  always_comb begin
    nxt_st = st_ff;
    nxt_st.fast_cnt = fast_tick ? '0 : st_ff.fast_cnt + 1'b1;
    nxt_st.slow_cnt = slow_tick ? '0 : st_ff.slow_cnt + 1'b1;
    nxt_st.pup_osc  = pup_tick ? '0 : st_ff.pup_osc + 1'b1;  // see R16
    nxt_st.osc_in_d = OSC_IN_PIN;

    // short low pulses never reach the counter's end
    if (MASTER_CLEAR_B) begin
      nxt_st.filt_cnt = '0;  // see R12
    end else if (!pin_rst) begin
      nxt_st.filt_cnt = st_ff.filt_cnt + 1'b1;
    end

    // register bus: address and data are taken together
    nxt_st.awready = AWVALID & WVALID & ~st_ff.awready & ~st_ff.bvalid;
    nxt_st.wready  = AWVALID & WVALID & ~st_ff.awready & ~st_ff.bvalid;
    if (wr_go) begin
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp  = RESP_OKAY;
      case (AWADDR)
        CFG_OFS: begin
          if (WSTRB[0]) begin
            nxt_st.fosc    = WDATA[2:0];
            nxt_st.pup_dis = WDATA[CFG_PUPDIS_BIT];
            nxt_st.bo_en   = WDATA[CFG_BOEN_BIT];
          end
        end
        PWRCTL_OFS: begin
          if (WSTRB[0]) begin
            nxt_st.bo_n    = WDATA[PC_BO_BIT];
            nxt_st.pon_n   = WDATA[PC_PON_BIT];  // see R22
            nxt_st.spd_sel = WDATA[PC_SPD_BIT];  // see R01
          end
        end
        STAT_OFS: ;
        KEEP_OFS: if (WSTRB[0]) nxt_st.keep = WDATA[7:0];
        default: nxt_st.bresp = RESP_SLVERR;
      endcase
    end else if (BREADY) begin
      nxt_st.bvalid = 1'b0;
    end

    nxt_st.arready = ARVALID & ~st_ff.arready & ~st_ff.rvalid;
    if (rd_go) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rresp  = RESP_OKAY;
      nxt_st.rdata  = '0;
      case (ARADDR)
        CFG_OFS: begin
          nxt_st.rdata[2:0]           = st_ff.fosc;
          nxt_st.rdata[CFG_PUPDIS_BIT] = st_ff.pup_dis;
          nxt_st.rdata[CFG_BOEN_BIT]  = st_ff.bo_en;
        end
        PWRCTL_OFS: begin
          nxt_st.rdata[PC_BO_BIT]  = st_ff.bo_n;
          nxt_st.rdata[PC_PON_BIT] = st_ff.pon_n;
          nxt_st.rdata[PC_SPD_BIT] = st_ff.spd_sel;
        end
        STAT_OFS: begin
          nxt_st.rdata[ST_PDN_BIT]            = st_ff.pdn;
          nxt_st.rdata[ST_TMO_BIT]            = st_ff.tmo;
          nxt_st.rdata[ST_CAUSE_LSB +: 3]     = st_ff.cause;  // see R08
          nxt_st.rdata[ST_BUSY_BIT]           = (st_ff.sw != SW_IDLE);
          nxt_st.rdata[ST_FAST_BIT]           = st_ff.active_fast;
          nxt_st.rdata[ST_INRST_BIT]          = st_ff.in_reset;
        end
        KEEP_OFS: nxt_st.rdata[7:0] = st_ff.keep;
        default: nxt_st.rresp = RESP_SLVERR;
      endcase
    end else if (RREADY) begin
      nxt_st.rvalid = 1'b0;
    end

    // reset sequencer; counters idle at zero outside their state
    nxt_st.pup_cnt   = '0;
    nxt_st.start_cnt = '0;
    case (st_ff.seq)
      SQ_SUPPLY: begin
        // only a rising supply matters here; a later fall is ignored
        if (POWER_GOOD) begin
          nxt_st.seq = first_timer(st_ff.pup_dis, crystal);  // see R13 see R14
        end
      end
      SQ_BROWN: begin
        if (!BROWN_OUT) begin
          nxt_st.seq = first_timer(st_ff.pup_dis, crystal);  // see R23
        end
      end
      SQ_PUP: begin
        nxt_st.pup_cnt = st_ff.pup_cnt + TW'(pup_tick);  // see R15
        if (pup_tick && st_ff.pup_cnt == TW'(PUP_TICKS_P - 1)) begin
          nxt_st.seq = crystal ? SQ_START : SQ_HOLD;
        end
      end
      SQ_START: begin
        nxt_st.start_cnt = st_ff.start_cnt + OW'(pin_edge);  // see R21
        if (pin_edge && st_ff.start_cnt == OW'(START_CYC_P - 1)) begin
          nxt_st.seq = st_ff.in_reset ? SQ_HOLD : SQ_RUN;
        end
      end
      SQ_HOLD: begin
        if (!pin_rst) begin
          nxt_st.seq      = SQ_RUN;
          nxt_st.in_reset = 1'b0;  // see R24
        end
      end
      SQ_RUN: begin
        if (pin_rst) begin
          nxt_st.seq      = SQ_HOLD;
          nxt_st.in_reset = 1'b1;
          nxt_st.spd_sel  = 1'b1;  // see R09
          nxt_st.cause    = CORE_SLEEP ? CAUSE_PIN_SLEEP : CAUSE_PIN_RUN;
          if (CORE_SLEEP) begin
            nxt_st.tmo = 1'b1;  // see R11
            nxt_st.pdn = 1'b0;
          end
        end else if (WATCHDOG_EXPIRED) begin
          nxt_st.tmo = 1'b0;  // see R11
          if (CORE_SLEEP) begin
            // wake resumes execution; registers stay as they are
            nxt_st.pdn   = 1'b0;
            nxt_st.cause = CAUSE_WATCHDOG_WAKE;  // see R09
            if (crystal) begin
              nxt_st.seq = SQ_START;  // see R21
            end
          end else begin
            nxt_st.seq      = SQ_HOLD;
            nxt_st.in_reset = 1'b1;
            nxt_st.spd_sel  = 1'b1;
            nxt_st.cause    = CAUSE_WATCHDOG_RUN;
          end
        end
      end
      default: nxt_st.seq = SQ_SUPPLY;
    endcase
    // brown-out outranks everything outside SQ_SUPPLY, and restarts any timer in progress
    if (bo_evt && st_ff.seq != SQ_SUPPLY) begin
      nxt_st.seq      = SQ_BROWN;  // see R23
      nxt_st.in_reset = 1'b1;
      nxt_st.spd_sel  = 1'b1;
      nxt_st.bo_n     = 1'b0;
      nxt_st.tmo      = 1'b1;
      nxt_st.pdn      = 1'b1;
      nxt_st.cause    = CAUSE_BROWN_OUT;
    end

    // speed change counts whole ticks of the running source, so no runt edge
    case (st_ff.sw)
      SW_IDLE: begin
        if (want_switch) begin
          nxt_st.sw     = SW_OLD;  // see R02
          nxt_st.sw_cnt = '0;
        end
      end
      SW_OLD: begin
        if (act_tick) begin
          nxt_st.sw_cnt = st_ff.sw_cnt + 1'b1;
          if (st_ff.sw_cnt == 3'(SW_OLD_TICKS - 1)) begin
            nxt_st.sw          = SW_NEW;  // see R03 see R25
            nxt_st.sw_cnt      = '0;
            nxt_st.active_fast = ~st_ff.active_fast;
          end
        end
      end
      SW_NEW: begin
        if (act_tick) begin
          nxt_st.sw_cnt = st_ff.sw_cnt + 1'b1;
          if (st_ff.sw_cnt == 3'(SW_NEW_TICKS - 1)) begin
            nxt_st.sw = SW_IDLE;  // see R03
          end
        end
      end
      default: nxt_st.sw = SW_IDLE;
    endcase

    nxt_st.clk_en = osc_tick & run;  // see R04
    if (osc_tick && run) begin
      nxt_st.phase = st_ff.phase + 1'b1;
    end
    if (divided_clock_out_mode) begin
      // moves only on a tick, so entering this mode makes no stray edge
      if (osc_tick && run) nxt_st.pin_o = nxt_st.phase[1];  // see R06 see R07
      nxt_st.pin_oe = 1'b1;
    end else if (gpio_mode) begin
      nxt_st.pin_o  = GPIO_OUT;  // see R06
      nxt_st.pin_oe = GPIO_OE;
    end else begin
      nxt_st.pin_o  = 1'b0;
      nxt_st.pin_oe = 1'b0;
    end
  end

  // keep register is never cleared by an internal reset
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      st_ff             <= '0;
      st_ff.fosc        <= CFG_RST[2:0];
      st_ff.pup_dis     <= CFG_RST[CFG_PUPDIS_BIT];
      st_ff.bo_en       <= CFG_RST[CFG_BOEN_BIT];
      st_ff.spd_sel     <= 1'b1;
      st_ff.active_fast <= 1'b1;
      st_ff.tmo         <= 1'b1;
      st_ff.pdn         <= 1'b1;
      st_ff.in_reset    <= 1'b1;
    end else begin
      st_ff <= nxt_st;  // see R10
    end
  end

  assign AWREADY        = st_ff.awready;
  assign WREADY         = st_ff.wready;
  assign BVALID         = st_ff.bvalid;
  assign BRESP          = st_ff.bresp;
  assign ARREADY        = st_ff.arready;
  assign RVALID         = st_ff.rvalid;
  assign RDATA          = st_ff.rdata;
  assign RRESP          = st_ff.rresp;
  assign SYS_CLK_EN     = st_ff.clk_en;
  assign CORE_RST_B     = ~st_ff.in_reset;
  assign OSC_OUT_PIN_O  = st_ff.pin_o;
  assign OSC_OUT_PIN_OE = st_ff.pin_oe;

  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_B);

  sequence s_old_done;
    st_ff.sw == SW_OLD && act_tick && st_ff.sw_cnt == 3'(SW_OLD_TICKS - 1);
  endsequence
  sequence s_enter_new;
    st_ff.sw == SW_NEW && st_ff.sw_cnt == 3'h0
      && st_ff.active_fast != $past(st_ff.active_fast);
  endsequence
  sequence s_brown_in_timer;
    st_ff.seq == SQ_PUP && bo_evt;
  endsequence
  sequence s_supply_back;
    st_ff.seq == SQ_BROWN && !BROWN_OUT && !st_ff.pup_dis;
  endsequence

  AST_HALT_IN_SWITCH: assert property (st_ff.sw != SW_IDLE |=> !SYS_CLK_EN)  // see R04
    else $error("system clock ran during speed change");
  AST_OLD_TWO_TICKS: assert property (s_old_done |=> s_enter_new)  // see R03
    else $error("speed flip not after second old tick");
  AST_NEW_EIGHT_TICKS: assert property (  // see R03
    st_ff.sw == SW_NEW && act_tick && st_ff.sw_cnt == 3'h7 |=> st_ff.sw == SW_IDLE)
    else $error("speed change not done after eighth new tick");
  AST_NO_SWITCH_EXT: assert property (  // see R02
    !internal && st_ff.sw == SW_IDLE |=> st_ff.sw == SW_IDLE)
    else $error("speed change started outside internal mode");
  AST_DIVIDED_CLOCK_OUT_ON_TICK: assert property (  // see R07
    divided_clock_out_mode && $past(divided_clock_out_mode) && $changed(OSC_OUT_PIN_O) |-> SYS_CLK_EN)
    else $error("clock out moved without a system tick");
  AST_GPIO_ROLE: assert property (  // see R06
    gpio_mode |=> OSC_OUT_PIN_O == $past(GPIO_OUT) && OSC_OUT_PIN_OE == $past(GPIO_OE))
    else $error("pin not following general purpose drive");
  AST_GLITCH_IGNORED: assert property (  // see R12
    st_ff.seq == SQ_RUN && st_ff.filt_cnt < LW'(FILT_CYC_P - 1) && !bo_evt
      && !WATCHDOG_EXPIRED |=> CORE_RST_B)
    else $error("short master clear pulse caused reset");
  AST_HELD_IN_RESET: assert property (  // see R24
    st_ff.seq inside {SQ_SUPPLY, SQ_BROWN, SQ_PUP, SQ_HOLD} |-> !CORE_RST_B)
    else $error("core released while a reset source is active");
  AST_TIMER_RESTART: assert property (  // see R23
    s_brown_in_timer ##1 s_supply_back |=> st_ff.seq == SQ_PUP && st_ff.pup_cnt == '0)
    else $error("power-up timer not restarted after brown-out");
  AST_WAKE_NO_RESET: assert property (  // see R09
    st_ff.seq == SQ_RUN && WATCHDOG_EXPIRED && CORE_SLEEP && !pin_rst && !bo_evt
      |=> CORE_RST_B && !st_ff.tmo && !st_ff.pdn ##1 CORE_RST_B)
    else $error("watchdog wake-up reset the core");
  AST_STARTUP_END: assert property (  // see R21
    st_ff.seq == SQ_START && pin_edge && st_ff.start_cnt == OW'(START_CYC_P - 1)
      |=> st_ff.seq != SQ_START)
    else $error("start-up wait overran its count");
  AST_PON_FLAG: assert property (st_ff.seq == SQ_SUPPLY |-> !st_ff.pon_n)  // see R22
    else $error("power-on flag set during power-on");
endmodule

// ==== design/clk_rst_pkg.sv ====
// Overview of operation
// R01 - software toggles internal clock 4 MHz / 37 kHz
// R02 - speed toggle only in internal oscillator mode
// R03 - switch waits two old, eight new ticks
// R04 - system clock and clock out halt meanwhile
// R05 - osc_speed_select bit picks fast or slow
// R06 - resistor-capacitor mode: pin is gpio or clock/4
// R07 - clock out runs at oscillator rate / 4
// R08 - six reset causes are told apart
// R09 - resets restore state, watchdog wake does not
// R10 - some registers survive every internal reset
// R11 - timeout and power-down flags mark cause
// R12 - master clear pin filtered against short glitches
// R13 - hold reset until supply good
// R14 - falling supply alone gives no reset
// R15 - power-up timer holds reset 72 ms
// R16 - power-up timer runs on own oscillator
// R17 - disable bit set turns power-up timer off
// R18 - enable power-up timer with brown-out (advice)
// R19 - internal mode makes nominal 4 MHz clock
// R20 - external party may drive oscillator input pin
// R21 - crystal modes wait 1024 input cycles
// R22 - power-on clears power-on flag, software sets it
// R23 - brown-out during timer restarts the timer
// R24 - release only when sources quiet, timers done
// R25 - speed switch makes no short clock pulse
package clk_rst_pkg;
  localparam int CLK_KHZ      = 125000;
  localparam int FAST_KHZ     = 4000;
  localparam int SLOW_KHZ     = 37;
  localparam int PUP_OSC_KHZ  = 37;
  localparam int PUP_MS       = 72;
  localparam int FILT_MIN_NS  = 2000;
  localparam int FAST_DIV     = CLK_KHZ / FAST_KHZ;
  localparam int SLOW_DIV     = CLK_KHZ / SLOW_KHZ;
  localparam int PUP_OSC_DIV  = CLK_KHZ / PUP_OSC_KHZ;
  localparam int PUP_TICKS    = PUP_MS * PUP_OSC_KHZ;
  localparam int FILT_CYC     = (FILT_MIN_NS * (CLK_KHZ / 1000) + 999) / 1000;
  localparam int STARTUP_CYC  = 1024;
  localparam int SW_OLD_TICKS = 2;
  localparam int SW_NEW_TICKS = 8;

  localparam logic [7:0] CFG_OFS    = 8'h00;
  localparam logic [7:0] PWRCTL_OFS = 8'h04;
  localparam logic [7:0] STAT_OFS   = 8'h08;
  localparam logic [7:0] KEEP_OFS   = 8'h0C;
  localparam logic [7:0] CFG_RST    = 8'h14;
  localparam int CFG_PUPDIS_BIT  = 3;
  localparam int CFG_BOEN_BIT    = 4;
  localparam int PC_BO_BIT       = 0;
  localparam int PC_PON_BIT      = 1;
  localparam int PC_SPD_BIT      = 3;
  localparam int ST_PDN_BIT      = 3;
  localparam int ST_TMO_BIT      = 4;
  localparam int ST_CAUSE_LSB    = 8;
  localparam int ST_BUSY_BIT     = 16;
  localparam int ST_FAST_BIT     = 17;
  localparam int ST_INRST_BIT    = 18;

  localparam logic [2:0] MODE_LOW_POWER_XTAL = 3'h0;
  localparam logic [2:0] MODE_XTAL           = 3'h1;
  localparam logic [2:0] MODE_FAST_XTAL      = 3'h2;
  localparam logic [2:0] MODE_EXT_CLOCK      = 3'h3;
  localparam logic [2:0] MODE_INT_GPIO       = 3'h4;
  localparam logic [2:0] MODE_INT_DIVIDED_CLOCK_OUT     = 3'h5;
  localparam logic [2:0] MODE_RESCAP_GPIO    = 3'h6;
  localparam logic [2:0] MODE_RESCAP_DIVIDED_CLOCK_OUT  = 3'h7;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {SQ_SUPPLY, SQ_BROWN, SQ_PUP, SQ_START, SQ_HOLD, SQ_RUN} seq_t;
  typedef enum logic [1:0] {SW_IDLE, SW_OLD, SW_NEW} spd_t;
  typedef enum logic [2:0] {
    CAUSE_POWER_ON, CAUSE_PIN_RUN, CAUSE_PIN_SLEEP,
    CAUSE_WATCHDOG_RUN, CAUSE_WATCHDOG_WAKE, CAUSE_BROWN_OUT
  } cause_t;
endpackage

// ==== verification/osc_pin_model.sv ====
module osc_pin_model (
  input  wire logic run,
  input  wire logic clr_low,
  output logic      osc,
  output logic      clr_b
);
  timeunit 1ns;
  timeprecision 100ps;

  // half period unrelated to the system clock; stands still while not running
  initial begin
    osc = 1'b0;
    #0.5;  // keeps pin edges off the system clock edges
    forever begin
      #23;
      if (run) osc = ~osc;
    end
  end

  // reset pin has a pull-up, so a released line reads high
  assign clr_b = clr_low ? 1'b0 : 1'b1;
endmodule

// ==== verification/clock_select_and_reset_sequencer_test.sv ====
module clock_select_and_reset_sequencer_test import clk_rst_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  import clk_rst_pkg::*;

  localparam int FD  = 2;
  localparam int SD  = 8;
  localparam int PUP = 16;

  logic        MCLK, RST_B, AWVALID, WVALID, BREADY, ARVALID, RREADY;
  logic        AWREADY, WREADY, BVALID, ARREADY, RVALID;
  logic [7:0]  AWADDR, ARADDR;
  logic [31:0] WDATA, RDATA, v;
  logic [3:0]  WSTRB;
  logic [1:0]  BRESP, RRESP;
  logic        POWER_GOOD, BROWN_OUT, MASTER_CLEAR_B, WATCHDOG_EXPIRED, CORE_SLEEP;
  logic        OSC_IN_PIN, GPIO_OUT, GPIO_OE, SYS_CLK_EN, CORE_RST_B;
  logic        OSC_OUT_PIN_O, OSC_OUT_PIN_OE, osc_run, clr_low;
  int          bad_count, checks, n, t, r, l;

  clk_rst_seq #(.FAST_DIV_P(FD), .SLOW_DIV_P(SD), .PUP_OSC_DIV_P(4), .PUP_TICKS_P(4),
    .FILT_CYC_P(4), .START_CYC_P(8)) i_clk_rst_seq (.MCLK, .RST_B, .AWVALID, .AWREADY,
    .AWADDR, .WVALID, .WREADY, .WDATA, .WSTRB, .BVALID, .BREADY, .BRESP, .ARVALID,
    .ARREADY, .ARADDR, .RVALID, .RREADY, .RDATA, .RRESP, .POWER_GOOD, .BROWN_OUT,
    .MASTER_CLEAR_B, .WATCHDOG_EXPIRED, .CORE_SLEEP, .OSC_IN_PIN, .GPIO_OUT, .GPIO_OE,
    .SYS_CLK_EN, .CORE_RST_B, .OSC_OUT_PIN_O, .OSC_OUT_PIN_OE);

  osc_pin_model i_osc_pin_model (.run(osc_run), .clr_low(clr_low), .osc(OSC_IN_PIN),
    .clr_b(MASTER_CLEAR_B));

  initial begin
    MCLK = 1'b0;
    forever #4 MCLK = ~MCLK;
  end

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic hang(input string nm);
    bad_count++;
    $display("[ERR] %s expected done seen timeout", nm);
    tally_and_finish();
  endtask

  task automatic done(input string nm);
    $display("test %s done, mismatches %0d", nm, bad_count);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    int k;
    k = 0;
    AWADDR  <= a;
    WDATA   <= d;
    AWVALID <= 1'b1;
    WVALID  <= 1'b1;
    BREADY  <= 1'b1;
    do begin
      @(posedge MCLK);
      k++;
      if (AWREADY === 1'b1) AWVALID <= 1'b0;
      if (WREADY === 1'b1) WVALID <= 1'b0;
    end while (BVALID !== 1'b1 && k < 40);
    BREADY <= 1'b0;
    if (k >= 40) hang("bvalid");
    chk("bresp", 32'(e), 32'(BRESP));
    @(posedge MCLK);
  endtask

  task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] m, e);
    int k;
    k = 0;
    ARADDR  <= a;
    ARVALID <= 1'b1;
    RREADY  <= 1'b1;
    do begin
      @(posedge MCLK);
      k++;
      if (ARREADY === 1'b1) ARVALID <= 1'b0;
    end while (RVALID !== 1'b1 && k < 40);
    v = RDATA;
    RREADY <= 1'b0;
    if (k >= 40) hang("rvalid");
    chk("rresp", 32'(RESP_OKAY), 32'(RRESP));
    chk(nm, e, v & m);
    @(posedge MCLK);
  endtask

  task automatic stat(input int c, input logic tm, input logic pd);
    rc("status", STAT_OFS, 32'h0000_0718,
       (32'(c) << ST_CAUSE_LSB) | (32'(tm) << ST_TMO_BIT) | (32'(pd) << ST_PDN_BIT));
  endtask

  task automatic wclk(output int k);
    k = 0;
    do begin
      @(posedge MCLK);
      k++;
    end while (SYS_CLK_EN !== 1'b1 && k < 400);
    if (k >= 400) hang("sys_clk_en");
  endtask

  task automatic wrst(input logic lvl, output int k);
    k = 0;
    do begin
      @(posedge MCLK);
      k++;
    end while (CORE_RST_B !== lvl && k < 400);
    if (k >= 400) hang("core_rst_b");
  endtask

  // counts ticks, clock-out rises and core reset cycles over a window
  task automatic win(input int c);
    logic p;
    t = 0;
    r = 0;
    l = 0;
    p = OSC_OUT_PIN_O;
    repeat (c) begin
      @(posedge MCLK);
      t += int'(SYS_CLK_EN === 1'b1);
      r += int'(OSC_OUT_PIN_O === 1'b1 && p === 1'b0);
      l += int'(CORE_RST_B !== 1'b1);
      p = OSC_OUT_PIN_O;
    end
  endtask

  task automatic dog;
    WATCHDOG_EXPIRED <= 1'b1;
    @(posedge MCLK);
    WATCHDOG_EXPIRED <= 1'b0;
  endtask

  initial begin
    #400000;
    hang("run");
  end

  initial begin
    {RST_B, AWVALID, WVALID, BREADY, ARVALID, RREADY, POWER_GOOD, BROWN_OUT} = '0;
    {WATCHDOG_EXPIRED, CORE_SLEEP, GPIO_OUT, GPIO_OE, osc_run, clr_low} = '0;
    {AWADDR, ARADDR, WDATA} = '0;
    WSTRB = 4'hf;
    bad_count = 0;
    checks = 0;
    repeat (8) @(posedge MCLK);
    RST_B <= 1'b1;
    rc("cfg", CFG_OFS, 32'hFFFF_FFFF, 32'(CFG_RST));
    rc("pwrctl", PWRCTL_OFS, 32'hFFFF_FFFF, 32'h0000_0008);
    stat(0, 1'b1, 1'b1);
    win(20);
    chk("held", 20, l);
    POWER_GOOD <= 1'b1;
    wrst(1'b1, n);
    chk("pup_len", 1, n >= PUP && n <= PUP + 12);
    wr(KEEP_OFS, 32'h0000_00A5, RESP_OKAY);
    wr(PWRCTL_OFS, 32'h0000_000B, RESP_OKAY);
    wr(8'h40, 32'h0000_0000, RESP_SLVERR);
    done("power_on");
    wclk(n);
    wclk(n);
    chk("fast_gap", FD, n);
    wr(CFG_OFS, 32'h0000_0015, RESP_OKAY);
    win(64);
    chk("divided_clock_out_rises", 1, r >= 7 && r <= 9);
    chk("divided_clock_out_ticks", 32, t);
    chk("divided_clock_out_oe", 1, OSC_OUT_PIN_OE);
    GPIO_OE <= 1'b1;
    GPIO_OUT <= 1'b1;
    wr(CFG_OFS, 32'h0000_0016, RESP_OKAY);
    win(2);
    chk("gpio_drive", 3, {OSC_OUT_PIN_OE, OSC_OUT_PIN_O});
    GPIO_OE <= 1'b0;
    GPIO_OUT <= 1'b0;
    win(2);
    chk("gpio_off", 0, {OSC_OUT_PIN_OE, OSC_OUT_PIN_O});
    done("clock_out");
    wr(CFG_OFS, 32'h0000_0014, RESP_OKAY);
    wr(PWRCTL_OFS, 32'h0000_0003, RESP_OKAY);
    wclk(n);
    chk("to_slow_gap", 1, n >= 56 && n <= 84);
    wclk(n);
    chk("slow_gap", SD, n);
    rc("fast_bit", STAT_OFS, 32'h0002_0000, 32'h0000_0000);
    wr(PWRCTL_OFS, 32'h0000_000B, RESP_OKAY);
    wclk(n);
    chk("to_fast_gap", 1, n >= 18 && n <= 44);
    wclk(n);
    chk("fast_again", FD, n);
    done("speed");
    osc_run <= 1'b1;
    wr(CFG_OFS, 32'h0000_0013, RESP_OKAY);
    wr(PWRCTL_OFS, 32'h0000_0003, RESP_OKAY);
    wclk(n);
    wclk(n);
    chk("ext_gap", 1, n >= 5 && n <= 6);
    wr(CFG_OFS, 32'h0000_0017, RESP_OKAY);
    win(64);
    chk("rc_divided_clock_out", 1, r >= 2 && r <= 3 && OSC_OUT_PIN_OE);
    wr(PWRCTL_OFS, 32'h0000_000B, RESP_OKAY);
    wr(CFG_OFS, 32'h0000_0014, RESP_OKAY);
    done("ext_clock");
    clr_low <= 1'b1;
    repeat (3) @(posedge MCLK);
    clr_low <= 1'b0;
    win(12);
    chk("glitch", 0, l);
    clr_low <= 1'b1;
    win(12);
    chk("pin_rst", 1, l > 0);
    clr_low <= 1'b0;
    wrst(1'b1, n);
    stat(1, 1'b1, 1'b1);
    rc("keep", KEEP_OFS, 32'h0000_00FF, 32'h0000_00A5);
    rc("pwrctl_pin", PWRCTL_OFS, 32'h0000_000B, 32'h0000_000B);
    done("pin_reset");
    dog();
    wrst(1'b0, n);
    wrst(1'b1, n);
    stat(3, 1'b0, 1'b1);
    wr(PWRCTL_OFS, 32'h0000_0003, RESP_OKAY);
    CORE_SLEEP <= 1'b1;
    dog();
    CORE_SLEEP <= 1'b0;
    win(12);
    chk("wake_no_rst", 0, l);
    stat(4, 1'b0, 1'b0);
    rc("pwrctl_wake", PWRCTL_OFS, 32'h0000_000B, 32'h0000_0003);
    done("watchdog");
    BROWN_OUT <= 1'b1;
    wrst(1'b0, n);
    BROWN_OUT <= 1'b0;
    repeat (6) @(posedge MCLK);
    BROWN_OUT <= 1'b1;
    repeat (1) @(posedge MCLK);
    BROWN_OUT <= 1'b0;
    wrst(1'b1, n);
    chk("bo_restart", 1, n >= PUP && n <= PUP + 12);
    stat(5, 1'b1, 1'b1);
    rc("pwrctl_bo", PWRCTL_OFS, 32'h0000_000B, 32'h0000_000A);
    wr(CFG_OFS, 32'h0000_001C, RESP_OKAY);
    BROWN_OUT <= 1'b1;
    wrst(1'b0, n);
    BROWN_OUT <= 1'b0;
    wrst(1'b1, n);
    chk("pup_off", 1, n < PUP);
    done("brown_out");
    POWER_GOOD <= 1'b0;
    win(20);
    chk("supply_drop", 0, l);
    POWER_GOOD <= 1'b1;
    wr(CFG_OFS, 32'h0000_0011, RESP_OKAY);
    CORE_SLEEP <= 1'b1;
    dog();
    CORE_SLEEP <= 1'b0;
    wclk(n);
    chk("xtal_wake", 1, n >= 40 && n <= 80);
    done("crystal");
    CORE_SLEEP <= 1'b1;
    clr_low <= 1'b1;
    win(12);
    {CORE_SLEEP, clr_low} <= 2'b00;
    wrst(1'b1, n);
    stat(2, 1'b1, 1'b0);
    done("pin_sleep");
    tally_and_finish();
  end
endmodule
